// [line_cfg_pkg.sv]
// Purpose: shared constants and types for the line mode and termination
//          configuration block
// Assumes: eight-bit microprocessor port, register data eight bits wide
// Notes:   every offset, field position and reset value of the stored settings and read data lives here
package line_cfg_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_MODE = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_TERM = 8'h32;
   localparam logic [ADDR_W-1:0] OFS_CODE = 8'h40;
   localparam logic [ADDR_W-1:0] OFS_SYS  = 8'h41;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h42;

   // operating_mode_select fields
   localparam int MODE_FMT_LSB = 0;
   localparam int MODE_VAR_BIT = 2;
   localparam int MODE_UNF_BIT = 3;
   localparam int MODE_STD_BIT = 4;
   localparam logic [DATA_W-1:0] MODE_MASK = 8'h1F;

   // receive termination fields
   localparam int TERM_EXT_BIT = 2;
   localparam logic [DATA_W-1:0] TERM_MASK = 8'h07;

   // line code control fields
   localparam int CODE_AMI_BIT = 0;
   localparam int CODE_BPV_BIT = 1;
   localparam logic [DATA_W-1:0] CODE_MASK = 8'h01;

   // system interface fields
   localparam int SYS_CONV_BIT = 0;
   localparam int SYS_MUX_BIT  = 1;
   localparam logic [DATA_W-1:0] SYS_MASK = 8'h03;

   // status fields
   localparam int STAT_STD_LSB  = 0;
   localparam int STAT_FMT_LSB  = 2;
   localparam int STAT_CODE_LSB = 4;
   localparam int STAT_HDLC_LSB = 6;

   // reset values
   localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
   localparam logic [DATA_W-1:0] TERM_RST = 8'h00;
   localparam logic [DATA_W-1:0] CODE_RST = 8'h00;
   localparam logic [DATA_W-1:0] SYS_RST  = 8'h00;
   localparam logic [DATA_W-1:0] RD_RST   = 8'h00;

   // frame format codes
   localparam logic [1:0] FMT_SF  = 2'h0;
   localparam logic [1:0] FMT_ESF = 2'h1;
   localparam logic [1:0] FMT_DM  = 2'h2;
   localparam logic [1:0] FMT_SLC = 2'h3;

   // data-link channel counts
   localparam logic [1:0] HDLC_NONE  = 2'h0;
   localparam logic [1:0] HDLC_TWO   = 2'h2;
   localparam logic [1:0] HDLC_THREE = 2'h3;

   typedef enum logic [1:0] {STD_E1, STD_T1, STD_J1} line_std_t;
   typedef enum logic [1:0] {CODE_HDB3, CODE_B8ZS, CODE_AMI} line_code_t;

endpackage : line_cfg_pkg

// [mode_caps_if.sv]
// Purpose: carries stored settings to the decoder and capabilities back
// Assumes: one clock domain, purely combinational between the ends
// Notes:   owner is the register bank, decoder is mode_decode
`timescale 1ns/100ps
`default_nettype none
interface mode_caps_if;
   import line_cfg_pkg::*;

   logic [DATA_W-1:0] modeReg;
   logic [DATA_W-1:0] termReg;
   logic [DATA_W-1:0] codeReg;
   logic [DATA_W-1:0] sysReg;
   line_std_t         std;
   logic [1:0]        fmt;
   logic              unframed;
   logic              termInternal;
   logic [1:0]        termSel;
   line_code_t        lineCode;
   logic              convEn;
   logic              muxEn;
   logic [1:0]        hdlcCh;

   modport owner (
      output modeReg, termReg, codeReg, sysReg,
      input  std, fmt, unframed, termInternal, termSel, lineCode,
      input  convEn, muxEn, hdlcCh
   );
   modport decoder (
      input  modeReg, termReg, codeReg, sysReg,
      output std, fmt, unframed, termInternal, termSel, lineCode,
      output convEn, muxEn, hdlcCh
   );
endinterface : mode_caps_if
`default_nettype wire

// [mode_decode.sv]
// Purpose: derives line standard, format, coding and channel counts
// Assumes: settings are already held in registers by the owner
// Notes:   purely combinational; the owner registers every result
`timescale 1ns/100ps
`default_nettype none
module mode_decode (
   // settings in, capabilities out
   mode_caps_if.decoder caps
);
   import line_cfg_pkg::*;

   always_comb begin
      caps.fmt      = caps.modeReg[MODE_FMT_LSB +: 2];
      caps.unframed = caps.modeReg[MODE_UNF_BIT];
      // standard bit low forces the first standard, variant then ignored
      if (!caps.modeReg[MODE_STD_BIT]) begin
         caps.std = STD_E1;
      end else if (caps.modeReg[MODE_VAR_BIT]) begin
         caps.std = STD_J1;
      end else begin
         caps.std = STD_T1;
      end
      if (caps.std == STD_E1) begin
         caps.fmt = FMT_SF;
      end

      caps.termInternal = !caps.termReg[TERM_EXT_BIT];
      caps.termSel      = caps.termReg[1:0];

      if (caps.codeReg[CODE_AMI_BIT]) begin
         caps.lineCode = CODE_AMI;
      end else if (caps.std == STD_E1) begin
         caps.lineCode = CODE_HDB3;
      end else begin
         caps.lineCode = CODE_B8ZS;
      end

      caps.convEn = caps.sysReg[SYS_CONV_BIT] && caps.std != STD_E1;
      caps.muxEn  = caps.sysReg[SYS_MUX_BIT];

      // no framing means no overhead positions to carry a data link
      if (caps.unframed) begin
         caps.hdlcCh = HDLC_NONE;
      end else if (caps.std == STD_E1) begin
         caps.hdlcCh = HDLC_THREE;
      end else if (caps.fmt == FMT_ESF || caps.fmt == FMT_DM) begin
         caps.hdlcCh = HDLC_THREE;
      end else begin
         caps.hdlcCh = HDLC_TWO;
      end
   end

endmodule : mode_decode
`default_nettype wire

// [line_mode_and_termination_config.sv]
// Purpose: register bank and decoded configuration for a single-line
//          transceiver: standard, frame format, termination, line code,
//          system-side rate conversion and bus multiplexing
// Assumes: microprocessor port already synchronous to clock; one access
//          per select cycle
// Notes:   all outputs are registered; decode is one cycle behind a write
//          a violation request fires together with the AMI line code,
//          so it never reaches a coder still running B8ZS or HDB3
//
// Functional notes
// - exactly one standard among three, full duplex
// - standard bit zero selects E1, ignores variant and format
// - T1 format codes: SF, ESF, DM, SLC-96
// - J1 permits only SF and ESF
// - unframed setting bypasses framing both directions
// - termination top bit zero enables internal network
// - internal codes select 75, 120, 100, 110 ohms
// - B8ZS for NORTH_AMERICAN_VARIANT_SELECT, HDB3 for E1, or AMI
// - bipolar violation insert only while AMI selected
// - NORTH_AMERICAN_VARIANT_SELECT optional 1.544 to 2.048 conversion
// - any mode optional 8.192 Mbit/s bus multiplexing
// - framed T1/J1 ESF/DM three channels, framed T1/J1 SF/SLC-96 two channels
// - framed E1 offers three transmit data-link channels
`timescale 1ns/100ps
`default_nettype none
module line_mode_and_termination_config (
   // clock and reset
   input  wire logic                            clock,
   input  wire logic                            sys_rst,
   // microprocessor port
   input  wire logic                            cpuSel,
   input  wire logic                            cpuWr,
   input  wire logic                            cpuRd,
   input  wire logic [line_cfg_pkg::ADDR_W-1:0] cpuAddr,
   input  wire logic [line_cfg_pkg::DATA_W-1:0] cpuWrData,
   output var  logic [line_cfg_pkg::DATA_W-1:0] cpuRdData,
   output var  logic                            cpuAck,
   // decoded mode
   output var  line_cfg_pkg::line_std_t         lineStd,
   output var  logic [1:0]                      frameFormat,
   output var  logic                            framingBypass,
   // termination
   output var  logic                            termInternalEn,
   output var  logic [1:0]                      termImpedanceSel,
   // line coding
   output var  line_cfg_pkg::line_code_t        lineCode,
   output var  logic                            bpvInsert,
   // system side
   output var  logic                            rateConvertEn,
   output var  logic                            busMuxEn,
   output var  logic [1:0]                      hdlcChannels
);
   import line_cfg_pkg::*;

   mode_caps_if caps ();

   // stored settings
   logic [DATA_W-1:0] modeReg_r;
   logic [DATA_W-1:0] modeReg_nxt;
   logic [DATA_W-1:0] termReg_r;
   logic [DATA_W-1:0] termReg_nxt;
   logic [DATA_W-1:0] codeReg_r;
   logic [DATA_W-1:0] codeReg_nxt;
   logic [DATA_W-1:0] sysReg_r;
   logic [DATA_W-1:0] sysReg_nxt;
   // violation request, held one cycle until the line code follows
   logic              bpvReq_r;
   logic              bpvReq_nxt;

   // port answer
   logic [DATA_W-1:0] rdData_r;
   logic [DATA_W-1:0] rdData_nxt;
   logic              ack_r;
   logic              ack_nxt;

   // registered capabilities
   line_std_t         std_r;
   line_std_t         std_nxt;
   logic [1:0]        fmt_r;
   logic [1:0]        fmt_nxt;
   logic              unf_r;
   logic              unf_nxt;
   logic              termInt_r;
   logic              termInt_nxt;
   logic [1:0]        termSel_r;
   logic [1:0]        termSel_nxt;
   line_code_t        code_r;
   line_code_t        code_nxt;
   logic              bpv_r;
   logic              bpv_nxt;
   logic              conv_r;
   logic              conv_nxt;
   logic              mux_r;
   logic              mux_nxt;
   logic [1:0]        hdlc_r;
   logic [1:0]        hdlc_nxt;

   // one decode of the offset serves both the write and the read side
   typedef enum logic [2:0] {
      SEL_MODE, SEL_TERM, SEL_CODE, SEL_SYS, SEL_STAT, SEL_NONE
   } reg_sel_t;

   reg_sel_t          accSel;
   logic              wrStb;
   logic              rdStb;
   logic [DATA_W-1:0] statusWord;

   assign caps.modeReg = modeReg_r;
   assign caps.termReg = termReg_r;
   assign caps.codeReg = codeReg_r;
   assign caps.sysReg  = sysReg_r;

   mode_decode u_decode (
      .caps (caps)
   );

   // unmapped offsets fall through to SEL_NONE and read as zero
   function automatic reg_sel_t reg_select(
      input logic [ADDR_W-1:0] addr
   );
      reg_sel_t sel;
      if (addr == OFS_MODE) begin
         sel = SEL_MODE;
      end else if (addr == OFS_TERM) begin
         sel = SEL_TERM;
      end else if (addr == OFS_CODE) begin
         sel = SEL_CODE;
      end else if (addr == OFS_SYS) begin
         sel = SEL_SYS;
      end else if (addr == OFS_STAT) begin
         sel = SEL_STAT;
      end else begin
         sel = SEL_NONE;
      end
      return sel;
   endfunction : reg_select

   assign wrStb  = cpuSel && cpuWr;
   assign rdStb  = cpuSel && cpuRd && !cpuWr;
   assign accSel = reg_select(cpuAddr);

   // a J1 setting with a T1-only format code is refused for the format
   // field only; standard, variant and unframed bits still take effect
   function automatic logic [DATA_W-1:0] mode_write(
      input logic [DATA_W-1:0] oldVal,
      input logic [DATA_W-1:0] newVal
   );
      logic [DATA_W-1:0] res;
      res = newVal & MODE_MASK;
      if (newVal[MODE_STD_BIT] && newVal[MODE_VAR_BIT] &&
          newVal[MODE_FMT_LSB+1]) begin
         res[MODE_FMT_LSB +: 2] = oldVal[MODE_FMT_LSB +: 2];
         // an old T1-only code, whatever standard stored it, is no valid J1
         // format either, so the frame falls back to super frame
         if (oldVal[MODE_FMT_LSB+1]) begin
            res[MODE_FMT_LSB +: 2] = FMT_SF;
         end
      end
      return res;
   endfunction : mode_write

   // status shows what the device actually runs, not what was written
   always_comb begin
      statusWord = '0;
      statusWord[STAT_STD_LSB  +: 2] = std_r;
      statusWord[STAT_FMT_LSB  +: 2] = fmt_r;
      statusWord[STAT_CODE_LSB +: 2] = code_r;
      statusWord[STAT_HDLC_LSB +: 2] = hdlc_r;
   end

   // register writes
   always_comb begin
      modeReg_nxt = modeReg_r;
      termReg_nxt = termReg_r;
      codeReg_nxt = codeReg_r;
      sysReg_nxt  = sysReg_r;
      bpvReq_nxt  = 1'b0;
      if (wrStb) begin
         if (accSel == SEL_MODE) begin
            modeReg_nxt = mode_write(modeReg_r, cpuWrData);
         end else if (accSel == SEL_TERM) begin
            termReg_nxt = cpuWrData & TERM_MASK;
         end else if (accSel == SEL_CODE) begin
            codeReg_nxt = cpuWrData & CODE_MASK;
            // the violation request is a strobe and never stored
            bpvReq_nxt = cpuWrData[CODE_BPV_BIT] &&
                         cpuWrData[CODE_AMI_BIT];
         end else if (accSel == SEL_SYS) begin
            sysReg_nxt = cpuWrData & SYS_MASK;
         end
      end
   end

   // register reads; unmapped offsets answer zero
   // a write leaves the last read value standing on the data lines
   always_comb begin
      rdData_nxt = rdData_r;
      ack_nxt    = wrStb || rdStb;
      if (rdStb) begin
         if (accSel == SEL_MODE) begin
            rdData_nxt = modeReg_r;
         end else if (accSel == SEL_TERM) begin
            rdData_nxt = termReg_r;
         end else if (accSel == SEL_CODE) begin
            rdData_nxt = codeReg_r;
         end else if (accSel == SEL_SYS) begin
            rdData_nxt = sysReg_r;
         end else if (accSel == SEL_STAT) begin
            rdData_nxt = statusWord;
         end else begin
            rdData_nxt = '0;
         end
      end
   end

   // capture decoded capabilities so every output leaves a flip-flop
   always_comb begin
      std_nxt     = caps.std;
      fmt_nxt     = caps.fmt;
      unf_nxt     = caps.unframed;
      termInt_nxt = caps.termInternal;
      termSel_nxt = caps.termSel;
      code_nxt    = caps.lineCode;
      conv_nxt    = caps.convEn;
      mux_nxt     = caps.muxEn;
      hdlc_nxt    = caps.hdlcCh;
      // the strobe waits a cycle so it meets the AMI code on the outputs
      bpv_nxt     = bpvReq_r && caps.lineCode == CODE_AMI;
   end

   // stored settings and the pending violation request
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         modeReg_r <= MODE_RST;
         termReg_r <= TERM_RST;
         codeReg_r <= CODE_RST;
         sysReg_r  <= SYS_RST;
         bpvReq_r  <= 1'b0;
      end else begin
         modeReg_r <= modeReg_nxt;
         termReg_r <= termReg_nxt;
         codeReg_r <= codeReg_nxt;
         sysReg_r  <= sysReg_nxt;
         bpvReq_r  <= bpvReq_nxt;
      end
   end

   // port answer registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdData_r <= RD_RST;
         ack_r    <= 1'b0;
      end else begin
         rdData_r <= rdData_nxt;
         ack_r    <= ack_nxt;
      end
   end

   // capabilities, one cycle behind the stored settings
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         std_r     <= STD_E1;
         fmt_r     <= FMT_SF;
         unf_r     <= 1'b0;
         termInt_r <= 1'b1;
         termSel_r <= 2'h0;
         code_r    <= CODE_HDB3;
         bpv_r     <= 1'b0;
         conv_r    <= 1'b0;
         mux_r     <= 1'b0;
         hdlc_r    <= HDLC_THREE;
      end else begin
         std_r     <= std_nxt;
         fmt_r     <= fmt_nxt;
         unf_r     <= unf_nxt;
         termInt_r <= termInt_nxt;
         termSel_r <= termSel_nxt;
         code_r    <= code_nxt;
         bpv_r     <= bpv_nxt;
         conv_r    <= conv_nxt;
         mux_r     <= mux_nxt;
         hdlc_r    <= hdlc_nxt;
      end
   end

   assign cpuRdData        = rdData_r;
   assign cpuAck           = ack_r;
   assign lineStd          = std_r;
   assign frameFormat      = fmt_r;
   assign framingBypass    = unf_r;
   assign termInternalEn   = termInt_r;
   assign termImpedanceSel = termSel_r;
   assign lineCode         = code_r;
   assign bpvInsert        = bpv_r;
   assign rateConvertEn    = conv_r;
   assign busMuxEn         = mux_r;
   assign hdlcChannels     = hdlc_r;

endmodule : line_mode_and_termination_config
`default_nettype wire

// [line_cfg_checker_assertions.sv]
// Purpose: port-level checks for the line configuration block
// Assumes: one clock, synchronous active-high reset
// Notes:   decoded outputs follow a write two edges later
`timescale 1ns/100ps
`default_nettype none
module line_cfg_checker
   import line_cfg_pkg::*;
(
   // clock and reset
   input wire logic              clock,
   input wire logic              sys_rst,
   // register port
   input wire logic              cpuSel,
   input wire logic              cpuWr,
   input wire logic              cpuRd,
   input wire logic [ADDR_W-1:0] cpuAddr,
   input wire logic [DATA_W-1:0] cpuWrData,
   input wire logic              cpuAck,
   // decoded outputs
   input wire line_std_t         lineStd,
   input wire logic [1:0]        frameFormat,
   input wire logic              framingBypass,
   input wire logic              termInternalEn,
   input wire logic [1:0]        termImpedanceSel,
   input wire line_code_t        lineCode,
   input wire logic              bpvInsert,
   input wire logic              rateConvertEn,
   input wire logic [1:0]        hdlcChannels
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic modeWr;
   logic termWr;
   assign modeWr = cpuSel && cpuWr && cpuAddr == OFS_MODE;
   assign termWr = cpuSel && cpuWr && cpuAddr == OFS_TERM;

   ack_after_req_a: assert property (
      cpuSel && (cpuWr || cpuRd) |=> cpuAck) else $error("ack missing");
   ack_cause_a: assert property (
      cpuAck |-> $past(cpuSel && (cpuWr || cpuRd)))
      else $error("ack without request");
   e1_write_a: assert property (
      modeWr && !cpuWrData[4] |-> ##2 lineStd == STD_E1
      && frameFormat == FMT_SF) else $error("E1 decode wrong");
   t1_format_a: assert property (
      modeWr && cpuWrData[4:2] == 3'b100 |-> ##2 lineStd == STD_T1
      && frameFormat == $past(cpuWrData[1:0], 2))
      else $error("T1 format wrong");
   j1_format_a: assert property (
      lineStd == STD_J1 |-> !frameFormat[1])
      else $error("T1-only format shown in J1");
   bypass_write_a: assert property (
      modeWr |-> ##2 framingBypass == $past(cpuWrData[3], 2))
      else $error("unframed setting wrong");
   term_write_a: assert property (
      termWr |-> ##2 termInternalEn == !$past(cpuWrData[2], 2)
      && termImpedanceSel == $past(cpuWrData[1:0], 2))
      else $error("termination wrong");
   code_std_a: assert property (
      lineCode != CODE_AMI |->
      (lineCode == CODE_HDB3) == (lineStd == STD_E1))
      else $error("line code mismatch");
   bpv_cause_a: assert property (
      bpvInsert |-> lineCode == CODE_AMI && $past(cpuSel && cpuWr
      && cpuAddr == OFS_CODE && cpuWrData[1:0] == 2'b11, 2))
      else $error("violation insert wrong");
   conv_std_a: assert property (
      rateConvertEn |-> lineStd != STD_E1)
      else $error("conversion in E1");
   hdlc_fmt_a: assert property (
      hdlcChannels == (framingBypass ? HDLC_NONE : (lineStd == STD_E1
      || frameFormat == FMT_ESF || frameFormat == FMT_DM) ? HDLC_THREE
      : HDLC_TWO)) else $error("channel count wrong");

   cover property (bpvInsert);
   cover property (lineStd == STD_J1 && frameFormat == FMT_ESF);
   cover property (!termInternalEn);
endmodule : line_cfg_checker

bind line_mode_and_termination_config line_cfg_checker chk (
   .clock(clock), .sys_rst(sys_rst), .cpuSel(cpuSel), .cpuWr(cpuWr),
   .cpuRd(cpuRd), .cpuAddr(cpuAddr), .cpuWrData(cpuWrData),
   .cpuAck(cpuAck), .lineStd(lineStd), .frameFormat(frameFormat),
   .framingBypass(framingBypass), .termInternalEn(termInternalEn),
   .termImpedanceSel(termImpedanceSel), .lineCode(lineCode),
   .bpvInsert(bpvInsert), .rateConvertEn(rateConvertEn),
   .hdlcChannels(hdlcChannels));
`default_nettype wire

// [line_mode_and_termination_config_tb.sv]
// Purpose: self-checking bench for the line configuration block
// Assumes: inputs driven on falling edges, one access at a time
// Notes:   driver queues expectations, monitor compares on acknowledge
`timescale 1ns/100ps
`default_nettype none
module line_mode_and_termination_config_tb;
   import line_cfg_pkg::*;
   typedef struct packed {logic rd; logic [7:0] dat; logic [14:0] cfg;} note_t;
   logic clock = 0, sys_rst = 1, cpuSel = 0, cpuWr = 0, cpuRd = 0;
   logic [7:0] cpuAddr = 8'h00, cpuWrData = 8'h00, cpuRdData, r8;
   logic cpuAck, framingBypass, termInternalEn, bpvInsert;
   logic rateConvertEn, busMuxEn, bpvE = 0;
   logic [1:0] frameFormat, termImpedanceSel, hdlcChannels;
   line_std_t lineStd;
   line_code_t lineCode;
   logic [7:0] mR = 8'h00, tR = 8'h00, cR = 8'h00, sR = 8'h00;
   logic [7:0] regs [6] = '{OFS_MODE, OFS_TERM, OFS_CODE, OFS_SYS,
                            OFS_STAT, 8'h55};
   logic [14:0] seen;
   note_t q[$];
   note_t n;
   int err_total = 0, checked = 0, seed = 32'h19d8825f, i, v;

   always #2 clock = ~clock;
   assign seen = {lineStd, frameFormat, framingBypass, termInternalEn,
      termImpedanceSel, lineCode, bpvInsert, rateConvertEn, busMuxEn,
      hdlcChannels};

   line_mode_and_termination_config uut (.clock(clock),
      .sys_rst(sys_rst), .cpuSel(cpuSel), .cpuWr(cpuWr), .cpuRd(cpuRd),
      .cpuAddr(cpuAddr), .cpuWrData(cpuWrData), .cpuRdData(cpuRdData),
      .cpuAck(cpuAck), .lineStd(lineStd), .frameFormat(frameFormat),
      .framingBypass(framingBypass), .termInternalEn(termInternalEn),
      .termImpedanceSel(termImpedanceSel), .lineCode(lineCode),
      .bpvInsert(bpvInsert), .rateConvertEn(rateConvertEn),
      .busMuxEn(busMuxEn), .hdlcChannels(hdlcChannels));

   function automatic logic [14:0] cfg_exp();
      logic [1:0] s, f, c, h;
      s = !mR[4] ? STD_E1 : (mR[2] ? STD_J1 : STD_T1);
      f = mR[4] ? mR[1:0] : FMT_SF;
      c = cR[0] ? CODE_AMI : (mR[4] ? CODE_B8ZS : CODE_HDB3);
      h = mR[3] ? HDLC_NONE : (!mR[4] || f == FMT_ESF || f == FMT_DM)
          ? HDLC_THREE : HDLC_TWO;
      return {s, f, mR[3], !tR[2], tR[1:0], c, bpvE, sR[0] & mR[4],
              sR[1], h};
   endfunction : cfg_exp

   task chk(input logic [14:0] got, input logic [14:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task results();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   // model update happens before the request so the note is complete
   task acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      note_t e;
      int k;
      bpvE = 0;
      e.cfg = cfg_exp();
      e.rd = !wr;
      e.dat = (a == OFS_MODE) ? mR : (a == OFS_TERM) ? tR :
              (a == OFS_CODE) ? cR : (a == OFS_SYS) ? sR :
              (a == OFS_STAT) ? {e.cfg[1:0], e.cfg[6:5], e.cfg[12:11],
              e.cfg[14:13]} : 8'h00;
      if (wr) begin
         case (a)
            OFS_MODE: mR = (d[4] & d[2] & d[1]) ?
                      {3'h0, d[4:2], mR[1] ? FMT_SF : mR[1:0]} :
                      d & MODE_MASK;
            OFS_TERM: tR = d & TERM_MASK;
            OFS_CODE: begin
               cR = d & CODE_MASK;
               bpvE = d[1] & d[0];
            end
            OFS_SYS: sR = d & SYS_MASK;
            default: ;
         endcase
      end
      e.cfg = cfg_exp();
      q.push_back(e);
      cpuSel = 1;
      cpuWr = wr;
      cpuRd = !wr;
      cpuAddr = a;
      cpuWrData = d;
      @(negedge clock);
      cpuSel = 0;
      cpuWr = 0;
      cpuRd = 0;
      for (k = 0; k < 4 && cpuAck !== 1'b1; k++) @(negedge clock);
      if (k == 4) begin
         err_total++;
         results();
      end else begin
         @(negedge clock);
      end
   endtask : acc

   initial forever begin
      @(negedge clock);
      if (cpuAck === 1'b1) begin
         if (q.size() == 0) chk(15'h0001, 15'h0000);
         else begin
            n = q.pop_front();
            if (n.rd) chk({7'h00, cpuRdData}, {7'h00, n.dat});
            @(negedge clock);
            chk(seen, n.cfg);
         end
      end
   end

   initial begin
      repeat (5) @(negedge clock);
      sys_rst = 0;
      for (i = 0; i < 6; i++) acc(0, regs[i], 8'h00);
      acc(1, OFS_MODE, 8'h15);
      acc(1, OFS_MODE, 8'h16);
      acc(1, OFS_MODE, 8'h13);
      acc(1, OFS_MODE, 8'h17);
      acc(0, OFS_MODE, 8'h00);
      repeat (40) begin
         r8 = 8'($random(seed));
         acc(1, OFS_MODE, r8);
         acc(0, OFS_STAT, 8'h00);
      end
      for (i = 0; i < 8; i++) begin
         acc(1, OFS_TERM, {5'h1F, 3'(i)});
         acc(0, OFS_TERM, 8'h00);
      end
      // walk line code and system bits under T1, E1 and J1
      foreach (regs[i]) if (i < 3) begin
         acc(1, OFS_MODE, (i == 0) ? 8'h10 : (i == 1) ? 8'h00 : 8'h14);
         for (v = 0; v < 4; v++) begin
            acc(1, OFS_CODE, 8'(v));
            acc(1, OFS_SYS, 8'(v));
            acc(0, OFS_SYS, 8'h00);
         end
      end
      acc(1, OFS_STAT, 8'hFF);
      acc(1, 8'h55, 8'hAA);
      acc(0, 8'h55, 8'h00);
      acc(0, OFS_STAT, 8'h00);
      repeat (3) @(negedge clock);
      results();
   end
endmodule : line_mode_and_termination_config_tb
`default_nettype wire
